// ---- design/pin_router_pkg.sv ----
// What this block does
// [R1] Every pin has its own selector whose 6-bit code picks its driver.
// [R2] Pin selector bits 7 and 6 ignore writes and read as zero.
// [R3] A routed peripheral may take over its pin's direction control.
// [R4] Lock register holds one bit at 0; while set no selection changes.
// [R5] With the lock clear, every selection register is writable.
// [R6] Power-on reset clears selectors; every reset clears the lock.
// [R7] Input codes are 5 bits, 4 bits for the interrupt and timer-0 clock.
// [R8] Code zero drives the pin from its port output latch bit.
// [R9] Lock changes only right after 0x55 then 0xAA to the lock register.
// [R10] With the one-way option the lock may be set only once per reset.
package pin_router_pkg;
   localparam int NUM_PINS      = 24;
   localparam int NUM_SRC       = 37;
   localparam int NUM_IN_FN     = 39;
   localparam int OUT_CODE_W    = 6;
   localparam int IN_CODE_W     = 5;
   localparam int NARROW_CODE_W = 4;
   localparam int ADDR_W        = 12;
   localparam int DATA_W        = 32;
   localparam int BYTE_W        = 8;
   localparam int LOCK_BIT      = 0;
   localparam int IN_FN_EXT_INT = 0;
   localparam int IN_FN_TMR0    = 1;

   localparam logic [ADDR_W-1:0] LOCK_OFS     = 12'h000;
   localparam logic [ADDR_W-1:0] IN_SEL_BASE  = 12'h100;
   localparam logic [ADDR_W-1:0] OUT_SEL_BASE = 12'h200;

   localparam logic [BYTE_W-1:0]     UNLOCK_KEY1    = 8'h55;
   localparam logic [BYTE_W-1:0]     UNLOCK_KEY2    = 8'hAA;
   localparam logic [OUT_CODE_W-1:0] OUT_SEL_RST    = 6'h00;
   localparam logic [OUT_CODE_W-1:0] OUT_CODE_LATCH = 6'h00;
   localparam logic [IN_CODE_W-1:0]  IN_SEL_RST     = 5'h00;
   localparam logic                  LOCK_RST       = 1'b0;

   typedef enum logic [2:0]
   {
      UNLOCK_IDLE      = 3'b001,
      UNLOCK_KEY1_SEEN = 3'b010,
      UNLOCK_ARMED     = 3'b100
   } unlock_state_e;

   // Writable bits of an input selector
   function automatic logic [IN_CODE_W-1:0] in_code_mask(input int idx);
      in_code_mask = (idx == IN_FN_EXT_INT || idx == IN_FN_TMR0) ?
                     5'h0F : 5'h1F;
   endfunction
endpackage

// ---- design/lock_ctrl_if.sv ----
`timescale 1ns/100ps
interface lock_ctrl_if;
   logic       wr_en;
   logic       lock_hit;
   logic [7:0] wdata;
   logic       armed;

   modport bus (output wr_en, output lock_hit, output wdata, input armed);
   modport seq (input wr_en, input lock_hit, input wdata, output armed);
endinterface

// ---- design/bit_sync.sv ----
`timescale 1ns/100ps
module bit_sync
#(
   parameter int W = 1
)
(
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         meta_ff <= '0;
         q       <= '0;
      end
      else
      begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule // bit_sync

// ---- design/unlock_sequencer.sv ----
`timescale 1ns/100ps
module unlock_sequencer
   import pin_router_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   lock_ctrl_if.seq lk
);
   unlock_state_e state_ff;
   unlock_state_e nxt_state;

   wire key1 = lk.lock_hit && (lk.wdata == UNLOCK_KEY1);
   wire key2 = lk.lock_hit && (lk.wdata == UNLOCK_KEY2);

   // Any bus write other than the next key or a repeated first key breaks the sequence
   always_comb
   begin
      nxt_state = state_ff;
      if (lk.wr_en)
      begin
         case (state_ff)
            UNLOCK_IDLE:
               nxt_state = key1 ? UNLOCK_KEY1_SEEN : UNLOCK_IDLE;
            UNLOCK_KEY1_SEEN:
               nxt_state = key2 ? UNLOCK_ARMED :
                           key1 ? UNLOCK_KEY1_SEEN : UNLOCK_IDLE;
            default:
               nxt_state = UNLOCK_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         state_ff <= UNLOCK_IDLE;
      else
         state_ff <= nxt_state; // see [R9]
   end

   assign lk.armed = (state_ff == UNLOCK_ARMED);
endmodule // unlock_sequencer

// ---- design/peripheral_pin_router.sv ----
`timescale 1ns/100ps
module peripheral_pin_router
   import pin_router_pkg::*;
(
   input  wire logic                               ref_clk,
   input  wire logic                               rst_n,
   input  wire logic                               por_rst_n,
   input  wire logic                               one_way_lock_option,
   input  wire logic                               hsel,
   input  wire logic [pin_router_pkg::ADDR_W-1:0]  haddr,
   input  wire logic [1:0]                         htrans,
   input  wire logic                               hwrite,
   input  wire logic [2:0]                         hsize,
   input  wire logic [pin_router_pkg::DATA_W-1:0]  hwdata,
   input  wire logic                               hready,
   output logic                                    hreadyout,
   output logic                                    hresp,
   output logic      [pin_router_pkg::DATA_W-1:0]  hrdata,
   input  wire logic [pin_router_pkg::NUM_PINS-1:0] port_output_latch_bit,
   input  wire logic [pin_router_pkg::NUM_PINS-1:0] pin_direction_control,
   input  wire logic [pin_router_pkg::NUM_SRC-1:0] periph_out,
   input  wire logic [pin_router_pkg::NUM_SRC-1:0] periph_dir_ovr,
   input  wire logic [pin_router_pkg::NUM_SRC-1:0] periph_drive,
   input  wire logic [pin_router_pkg::NUM_PINS-1:0] pin_in,
   output logic      [pin_router_pkg::NUM_PINS-1:0] pin_out,
   output logic      [pin_router_pkg::NUM_PINS-1:0] pin_oe_n,
   output logic      [pin_router_pkg::NUM_IN_FN-1:0] periph_in,
   output logic                                    selection_locked_bit
);
   import pin_router_pkg::*;

   localparam int IN_IDX_W  = $clog2(NUM_IN_FN);
   localparam int OUT_IDX_W = $clog2(NUM_PINS);

   localparam logic [OUT_CODE_W-1:0] SRC_MAX   = OUT_CODE_W'(NUM_SRC);
   localparam logic [IN_CODE_W-1:0]  PIN_LIMIT = IN_CODE_W'(NUM_PINS);

   // True when a word address lies in a block of n registers
   function automatic logic region_hit
   (
      input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] base,
      input int                n
   );
      logic [ADDR_W-1:0] ofs;
      ofs        = a - base;
      region_hit = (ofs[1:0] == 2'b00) && (int'(ofs) < n * 4);
   endfunction

   // Selection storage
   logic [OUT_CODE_W-1:0] out_sel_ff [NUM_PINS];
   logic [IN_CODE_W-1:0]  in_sel_ff  [NUM_IN_FN];
   logic                  lock_ff;
   logic                  lock_used_ff;

   // Bus slave state
   logic                  wr_pend_ff;
   logic                  rd_pend_ff;
   logic [ADDR_W-1:0]     addr_ff;
   logic                  hreadyout_ff;
   logic [DATA_W-1:0]     hrdata_ff;
   logic                  hresp_ff;

   // Pin and peripheral facing registers
   logic [NUM_PINS-1:0]   pin_out_ff;
   logic [NUM_PINS-1:0]   pin_oe_n_ff;
   logic [NUM_IN_FN-1:0]  periph_in_ff;

   wire                   any_rst_n;
   wire                   one_way;
   wire [NUM_PINS-1:0]    pin_sync;

   // Either reset source clears the lock and the bus side
   assign any_rst_n = rst_n && por_rst_n; // see [R6]

   bit_sync
   #(
      .W (NUM_PINS)
   )
   u_pin_sync
   (
      .ref_clk (ref_clk),
      .rst_n   (any_rst_n),
      .d       (pin_in),
      .q       (pin_sync)
   );

   bit_sync
   #(
      .W (1)
   )
   u_opt_sync
   (
      .ref_clk (ref_clk),
      .rst_n   (any_rst_n),
      .d       (one_way_lock_option),
      .q       (one_way)
   );

   // Address phase and data phase decode
   wire addr_phase = hsel && htrans[1] && hready;

   wire [ADDR_W-1:0]    in_ofs  = addr_ff - IN_SEL_BASE;
   wire [ADDR_W-1:0]    out_ofs = addr_ff - OUT_SEL_BASE;
   wire [IN_IDX_W-1:0]  in_idx  = in_ofs[IN_IDX_W+1:2];
   wire [OUT_IDX_W-1:0] out_idx = out_ofs[OUT_IDX_W+1:2];

   wire lock_hit = (addr_ff == LOCK_OFS);
   wire in_hit   = region_hit(addr_ff, IN_SEL_BASE, NUM_IN_FN);
   wire out_hit  = region_hit(addr_ff, OUT_SEL_BASE, NUM_PINS);

   // Selection writes pass only while unlocked
   wire sel_wr_ok = wr_pend_ff && !lock_ff; // see [R4] see [R5]
   wire in_wr     = sel_wr_ok && in_hit;
   wire out_wr    = sel_wr_ok && out_hit;

   lock_ctrl_if lk ();

   assign lk.wr_en    = wr_pend_ff;
   assign lk.lock_hit = lock_hit;
   assign lk.wdata    = hwdata[BYTE_W-1:0];

   unlock_sequencer u_unlock
   (
      .ref_clk (ref_clk),
      .rst_n   (any_rst_n),
      .lk      (lk.seq)
   );

   // Once set under the one-way option the lock cannot move again
   wire lock_frozen = one_way && lock_used_ff;             // see [R10]
   wire lock_wr     = wr_pend_ff && lock_hit && lk.armed   // see [R9]
                      && !lock_frozen;

   // Read data, unimplemented bits as zero
   wire [BYTE_W-1:0] rd_lock = {7'h00, lock_ff};              // see [R4]
   wire [BYTE_W-1:0] rd_in   = {3'h0, in_sel_ff[in_idx]};     // see [R7]
   wire [BYTE_W-1:0] rd_out  = {2'h0, out_sel_ff[out_idx]};   // see [R2]

   wire [BYTE_W-1:0] rd_byte = lock_hit ? rd_lock :
                               in_hit   ? rd_in   :
                               out_hit  ? rd_out  : 8'h00;

   // Bus handshake; reads take one wait state so that a read
   // right behind a write sees the written value
   always_ff @(posedge ref_clk)
   begin
      if (!any_rst_n)
      begin
         wr_pend_ff   <= 1'b0;
         rd_pend_ff   <= 1'b0;
         addr_ff      <= '0;
         hreadyout_ff <= 1'b1;
         hrdata_ff    <= '0;
         hresp_ff     <= 1'b0;
      end
      else
      begin
         wr_pend_ff <= addr_phase && hwrite;
         hresp_ff   <= 1'b0;
         if (addr_phase)
         begin
            addr_ff      <= haddr;
            rd_pend_ff   <= !hwrite;
            hreadyout_ff <= hwrite;
         end
         else if (rd_pend_ff)
         begin
            hrdata_ff    <= {24'h000000, rd_byte};
            rd_pend_ff   <= 1'b0;
            hreadyout_ff <= 1'b1;
         end
      end
   end

   // Lock bit
   always_ff @(posedge ref_clk)
   begin
      if (!any_rst_n)
      begin
         lock_ff      <= LOCK_RST; // see [R6]
         lock_used_ff <= 1'b0;
      end
      else if (lock_wr)
      begin
         lock_ff <= hwdata[LOCK_BIT];
         if (hwdata[LOCK_BIT])
            lock_used_ff <= 1'b1; // see [R10]
      end
   end

   // Selectors keep their value across resets other than power-on
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++)
      begin : g_out_sel
         always_ff @(posedge ref_clk)
         begin
            if (!por_rst_n)
               out_sel_ff[g] <= OUT_SEL_RST; // see [R6]
            else if (out_wr && out_idx == OUT_IDX_W'(g))
               out_sel_ff[g] <= hwdata[OUT_CODE_W-1:0]; // see [R1]
         end
      end

      for (g = 0; g < NUM_IN_FN; g++)
      begin : g_in_sel
         always_ff @(posedge ref_clk)
         begin
            if (!por_rst_n)
               in_sel_ff[g] <= IN_SEL_RST;
            else if (in_wr && in_idx == IN_IDX_W'(g))
               in_sel_ff[g] <= hwdata[IN_CODE_W-1:0]
                               & in_code_mask(g); // see [R7]
         end
      end
   endgenerate

   // Output routing; unsupported codes drive low under software
   // direction control
   wire [NUM_PINS-1:0] nxt_pin_out;
   wire [NUM_PINS-1:0] nxt_pin_drive;

   generate
      for (g = 0; g < NUM_PINS; g++)
      begin : g_pin
         wire [OUT_CODE_W-1:0] code = out_sel_ff[g];
         wire [OUT_CODE_W-1:0] src  = code - 6'h01;
         wire latch_sel = (code == OUT_CODE_LATCH);
         wire src_ok    = !latch_sel && (code <= SRC_MAX);
         wire ovr       = src_ok && periph_dir_ovr[src];

         assign nxt_pin_out[g] =
            latch_sel ? port_output_latch_bit[g] : // see [R8]
            src_ok    ? periph_out[src] : 1'b0;   // see [R1]

         assign nxt_pin_drive[g] =
            ovr ? periph_drive[src] :             // see [R3]
                  !pin_direction_control[g];
      end
   endgenerate

   // Input routing from synchronised pins
   wire [NUM_IN_FN-1:0] nxt_periph_in;

   generate
      for (g = 0; g < NUM_IN_FN; g++)
      begin : g_fn
         wire [IN_CODE_W-1:0] pcode = in_sel_ff[g];

         assign nxt_periph_in[g] =
            (pcode < PIN_LIMIT) ? pin_sync[pcode] : 1'b0; // see [R7]
      end
   endgenerate

   // Pins released while in reset
   always_ff @(posedge ref_clk)
   begin
      if (!any_rst_n)
      begin
         pin_out_ff   <= '0;
         pin_oe_n_ff  <= '1;
         periph_in_ff <= '0;
      end
      else
      begin
         pin_out_ff   <= nxt_pin_out;
         pin_oe_n_ff  <= ~nxt_pin_drive;
         periph_in_ff <= nxt_periph_in;
      end
   end

   assign hreadyout            = hreadyout_ff;
   assign hresp                = hresp_ff;
   assign hrdata               = hrdata_ff;
   assign pin_out              = pin_out_ff;
   assign pin_oe_n             = pin_oe_n_ff;
   assign periph_in            = periph_in_ff;
   assign selection_locked_bit = lock_ff;
endmodule // peripheral_pin_router

// ---- tb/pin_periph_model.sv ----
`timescale 1ns/100ps
module pin_periph_model
   import pin_router_pkg::*;
(
   input  wire logic [NUM_PINS-1:0] pin_out,
   input  wire logic [NUM_PINS-1:0] pin_oe_n,
   input  wire logic [NUM_PINS-1:0] ext_lvl,
   output logic      [NUM_SRC-1:0]  periph_out,
   output logic      [NUM_SRC-1:0]  periph_dir_ovr,
   output logic      [NUM_SRC-1:0]  periph_drive,
   output logic      [NUM_PINS-1:0] pin_in
);
   // Mixed patterns so that a wrong source index shows on some pin
   assign periph_out     = 37'h15A3C0F96E;
   assign periph_dir_ovr = 37'h0F0F0F0F0F;
   assign periph_drive   = 37'h1333333333;
   // A released pin takes the level the outside world puts on it
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);
endmodule // pin_periph_model

// ---- tb/peripheral_pin_router_chk.sv ----
`timescale 1ns/100ps
module peripheral_pin_router_chk
   import pin_router_pkg::*;
(
   input wire logic                ref_clk,
   input wire logic                rst_n,
   input wire logic                por_rst_n,
   input wire logic                one_way_lock_option,
   input wire logic                hsel,
   input wire logic [ADDR_W-1:0]   haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic [DATA_W-1:0]   hwdata,
   input wire logic                hready,
   input wire logic                hreadyout,
   input wire logic [DATA_W-1:0]   hrdata,
   input wire logic [NUM_PINS-1:0] port_output_latch_bit,
   input wire logic [NUM_PINS-1:0] pin_direction_control,
   input wire logic [NUM_SRC-1:0]  periph_out,
   input wire logic [NUM_SRC-1:0]  periph_dir_ovr,
   input wire logic [NUM_SRC-1:0]  periph_drive,
   input wire logic [NUM_PINS-1:0] pin_out,
   input wire logic [NUM_PINS-1:0] pin_oe_n,
   input wire logic                selection_locked_bit
);
   logic              aw_ff;
   logic              used_ff;
   logic [ADDR_W-1:0] aa_ff;
   logic [5:0]        code_ff;
   wire               take = hsel & htrans[1] & hready;
   wire               lk_ph = aw_ff & (aa_ff == LOCK_OFS);
   wire  [5:0]        c = code_ff - 6'h01;
   wire               rs = rst_n & por_rst_n;
   always_ff @(posedge ref_clk)
   begin
      aw_ff   <= rs & take & hwrite;
      aa_ff   <= take ? haddr : aa_ff;
      used_ff <= rs & (used_ff | (selection_locked_bit & one_way_lock_option));
   end
   // Shadow of pin 0's selector, kept only across non-POR resets
   always_ff @(posedge ref_clk)
   begin
      if (!por_rst_n)
         code_ff <= OUT_SEL_RST;
      else if (aw_ff && aa_ff == OUT_SEL_BASE && !selection_locked_bit)
         code_ff <= hwdata[5:0];
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n || !por_rst_n);
   a_high_bits_zero:
   assert property (hrdata[31:6] == 26'h0) else $error("high bits set");
   a_lock_on_write:
   assert property ($changed(selection_locked_bit) |-> $past(lk_ph) &&
      $past(hwdata[0]) == selection_locked_bit) else $error("lock moved");
   a_lock_reset:
   assert property (disable iff (1'b0) !rst_n || !por_rst_n |=>
      !selection_locked_bit) else $error("lock kept over reset");
   a_latch_route:
   assert property (code_ff == 6'h00 |=>
      pin_out[0] == $past(port_output_latch_bit[0]) &&
      pin_oe_n[0] == $past(pin_direction_control[0]))
      else $error("latch not routed");
   a_periph_route:
   assert property (code_ff inside {[6'h01:6'h25]} |=>
      pin_out[0] == $past(periph_out[c]) &&
      pin_oe_n[0] == ($past(periph_dir_ovr[c]) ? !$past(periph_drive[c])
      : $past(pin_direction_control[0]))) else $error("source misrouted");
   a_one_way_once:
   assert property ($fell(selection_locked_bit) |-> !$past(used_ff))
      else $error("one-way lock cleared");
   a_read_wait:
   assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait wrong");
   a_write_nowait:
   assert property (take && hwrite |=> hreadyout) else $error("write stall");
   cover property (take && !hwrite);
   cover property ($rose(selection_locked_bit));
   cover property (code_ff == 6'h05);
endmodule // peripheral_pin_router_chk
bind peripheral_pin_router peripheral_pin_router_chk u_chk
(
   .ref_clk(ref_clk), .rst_n(rst_n), .por_rst_n(por_rst_n),
   .one_way_lock_option(one_way_lock_option), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata),
   .port_output_latch_bit(port_output_latch_bit),
   .pin_direction_control(pin_direction_control), .periph_out(periph_out),
   .periph_dir_ovr(periph_dir_ovr), .periph_drive(periph_drive),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n),
   .selection_locked_bit(selection_locked_bit)
);

// ---- tb/peripheral_pin_router_bench.sv ----
`timescale 1ns/100ps
module peripheral_pin_router_bench;
   import pin_router_pkg::*;
   logic [NUM_PINS-1:0]  latch, dir, ext, pin_in, pin_out, pin_oe_n, eo, ee;
   logic [NUM_SRC-1:0]   pout, ovr, drv;
   logic [NUM_IN_FN-1:0] periph_in;
   logic [ADDR_W-1:0]    haddr;
   logic [DATA_W-1:0]    hwdata, hrdata, rv;
   logic [1:0]           htrans;
   logic [2:0]           hsize;
   logic                 ref_clk, rst_n, por_rst_n, one_way, hsel, hwrite;
   logic                 hreadyout, hresp, locked;
   int                   miscompares, checks_done, cycles;
   peripheral_pin_router u_peripheral_pin_router
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .por_rst_n(por_rst_n),
      .one_way_lock_option(one_way), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .port_output_latch_bit(latch),
      .pin_direction_control(dir), .periph_out(pout), .periph_dir_ovr(ovr),
      .periph_drive(drv), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .periph_in(periph_in),
      .selection_locked_bit(locked)
   );
   pin_periph_model u_pin_periph_model
   (
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext),
      .periph_out(pout), .periph_dir_ovr(ovr), .periph_drive(drv),
      .pin_in(pin_in)
   );
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rv, e);
   endtask
   task automatic set_lock(input logic v);
      xfer(1'b1, LOCK_OFS, 32'h55);
      xfer(1'b1, LOCK_OFS, 32'hAA);
      xfer(1'b1, LOCK_OFS, {31'h0, v});
   endtask
   function automatic logic [11:0] pa(input int p);
      pa = OUT_SEL_BASE + 12'(4 * p);
   endfunction
   initial
   begin
      {rst_n, por_rst_n, one_way, hsel, hwrite, htrans} = '0;
      {haddr, hwdata, miscompares, checks_done, cycles} = '0;
      hsize = 3'h2;
      latch = 24'hA5C396;
      dir = 24'h0F0F0F;
      ext = 24'h3C5A69;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      por_rst_n <= 1'b1;
      for (int p = 0; p < NUM_PINS; p++)
         rc(pa(p), 32'h0);
      rc(LOCK_OFS, 32'h0);
      $display("reset values done");
      for (int i = 0; i < NUM_IN_FN; i++)
      begin
         xfer(1'b1, IN_SEL_BASE + 12'(4 * i), 32'hFFFFFFFF);
         rc(IN_SEL_BASE + 12'(4 * i), i < 2 ? 32'h0F : 32'h1F);
      end
      for (int p = 0; p < NUM_PINS; p++)
      begin
         xfer(1'b1, pa(p), 32'hFFFFFFC0 | 32'(p + 1));
         rc(pa(p), 32'(p + 1));
         eo[p] = pout[p];
         ee[p] = ovr[p] ? !drv[p] : dir[p];
      end
      xfer(1'b1, 12'h300, 32'h1F);
      rc(12'h300, 32'h0);
      chk(pin_out, eo);
      chk(pin_oe_n, ee);
      chk(periph_in[28], 1'b0);
      xfer(1'b1, pa(5), 32'h0);
      xfer(1'b1, IN_SEL_BASE + 12'(4 * 28), 32'h05);
      repeat (4) @(posedge ref_clk);
      chk({pin_oe_n[5], pin_out[5]}, {dir[5], latch[5]});
      chk(periph_in[28], latch[5]);
      $display("routing done");
      xfer(1'b1, LOCK_OFS, 32'h01);
      rc(LOCK_OFS, 32'h0);
      set_lock(1'b1);
      rc(LOCK_OFS, 32'h1);
      xfer(1'b1, pa(0), 32'h0);
      rc(pa(0), 32'h01);
      xfer(1'b1, IN_SEL_BASE, 32'h0);
      rc(IN_SEL_BASE, 32'h0F);
      xfer(1'b1, LOCK_OFS, 32'h55);
      xfer(1'b1, pa(0), 32'h03);
      xfer(1'b1, LOCK_OFS, 32'hAA);
      xfer(1'b1, LOCK_OFS, 32'h0);
      rc(LOCK_OFS, 32'h1);
      set_lock(1'b0);
      rc(LOCK_OFS, 32'h0);
      xfer(1'b1, pa(0), 32'h02);
      rc(pa(0), 32'h02);
      set_lock(1'b1);
      $display("lock done");
      rst_n <= 1'b0;
      one_way <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rc(LOCK_OFS, 32'h0);
      rc(pa(0), 32'h02);
      set_lock(1'b0);
      set_lock(1'b1);
      set_lock(1'b0);
      rc(LOCK_OFS, 32'h1);
      por_rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      por_rst_n <= 1'b1;
      rc(pa(0), 32'h0);
      rc(LOCK_OFS, 32'h0);
      $display("one-way and resets done");
      give_verdict();
   end
endmodule // peripheral_pin_router_bench
